/* File: logic/msp_cfg_if.sv */
// Interface: configuration fields from register file to modem control
`timescale 1ns/10ps
interface msp_cfg_if;
  logic [1:0] zero_count;
  logic       avg_mode;
  logic [3:0] pre_len;
  logic       tx_filter;
  logic [4:0] correlation_threshold;
  logic [7:0] freq_est;
  logic       sync_found;
  logic       tx_busy;
  modport regs (output zero_count, avg_mode, pre_len, tx_filter, correlation_threshold,
                input  freq_est, sync_found, tx_busy);
  modport ctrl (input  zero_count, avg_mode, pre_len, tx_filter, correlation_threshold,
                output freq_est, sync_found, tx_busy);
endinterface : msp_cfg_if

/* File: logic/msp_modem_ctrl.sv */
// Module: sync search, offset averaging and preamble sequencing
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module msp_modem_ctrl
  import msp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  msp_cfg_if.ctrl         cfg,
  input  wire logic       demod_en,
  input  wire logic       sym_valid,
  input  wire logic       sym_is_zero,
  input  wire logic [4:0] sym_corr,
  input  wire logic       sync_word,
  input  wire logic       frame_end,
  input  wire logic [7:0] offset_sample,
  input  wire logic       tx_start,
  input  wire logic       tx_sym_tick,
  output logic            tx_sym_zero,
  output logic            tx_delim,
  output logic            tx_extra_filter,
  output logic            sync_pulse
);
  typedef struct packed {
    msp_rx_e    rx;
    logic [1:0] zeros;
    logic       corr_ok;
    logic [7:0] est;
    msp_tx_e    tx;
    logic [5:0] tx_left;
    logic       sym_zero;
    logic       delim;
    logic       filt;
    logic       sync;
  } msp_mc_s;

  msp_mc_s st_q, st_d;

  // One averaging step on signed values: drop a quarter, add a quarter
  function automatic logic [7:0] avg_step(input logic signed [7:0] e,
                                          input logic signed [7:0] s);
    logic signed [7:0] e_qtr;
    logic signed [7:0] s_qtr;
    e_qtr    = e >>> 2;
    s_qtr    = s >>> 2;
    avg_step = e - e_qtr + s_qtr;
  endfunction : avg_step

  // Next-state logic
  always_comb begin
    st_d          = st_q;
    st_d.sync     = 1'b0;
    st_d.delim    = 1'b0;
    st_d.sym_zero = 1'b0;
    st_d.filt     = cfg.tx_filter;
    case (st_q.rx)
      MSP_RX_SEARCH: begin
        if (!demod_en) begin
          st_d.zeros   = 2'h0;
          st_d.corr_ok = 1'b0;
        end else begin
          if (sym_valid) begin
            if (sym_is_zero) begin
              if (st_q.zeros != 2'h3) st_d.zeros = st_q.zeros + 2'h1;
              if (sym_corr > cfg.correlation_threshold) st_d.corr_ok = 1'b1;
            end else if (!sync_word) begin
              st_d.zeros   = 2'h0;
              st_d.corr_ok = 1'b0;
            end
          end
          // Offset averaging tracks while searching
          st_d.est = avg_step(st_q.est, offset_sample);
          if (sync_word && st_q.zeros >= cfg.zero_count
              && st_q.corr_ok) begin
            st_d.rx   = MSP_RX_LOCKED;
            st_d.sync = 1'b1;
          end
        end
      end
      MSP_RX_LOCKED: begin
        if (cfg.avg_mode && demod_en) begin
          st_d.est = avg_step(st_q.est, offset_sample);
        end
        if (frame_end || !demod_en) begin
          st_d.rx      = MSP_RX_SEARCH;
          st_d.zeros   = 2'h0;
          st_d.corr_ok = 1'b0;
          if (!cfg.avg_mode) st_d.est = 8'h00;
        end
      end
      default: st_d.rx = MSP_RX_SEARCH;
    endcase
    // Transmit preamble sequencing
    case (st_q.tx)
      MSP_TX_IDLE: begin
        if (tx_start) begin
          st_d.tx      = MSP_TX_PREAMBLE;
          st_d.tx_left = 6'({cfg.pre_len + MSP_PRE_BYTE_ADD, 1'b0});
        end
      end
      MSP_TX_PREAMBLE: begin
        if (tx_sym_tick) begin
          st_d.sym_zero = 1'b1;
          st_d.tx_left  = st_q.tx_left - 6'h01;
          if (st_q.tx_left == 6'h01) st_d.tx = MSP_TX_DELIM;
        end
      end
      MSP_TX_DELIM: begin
        if (tx_sym_tick) begin
          st_d.delim = 1'b1;
          st_d.tx    = MSP_TX_IDLE;
        end
      end
      default: st_d.tx = MSP_TX_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{rx: MSP_RX_SEARCH, tx: MSP_TX_IDLE, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg.freq_est    = st_q.est;
  assign cfg.sync_found  = (st_q.rx == MSP_RX_LOCKED);
  assign cfg.tx_busy     = (st_q.tx != MSP_TX_IDLE);
  assign tx_sym_zero     = st_q.sym_zero;
  assign tx_delim        = st_q.delim;
  assign tx_extra_filter = st_q.filt;
  assign sync_pulse      = st_q.sync;
endmodule : msp_modem_ctrl

/* File: logic/msp_pkg.sv */
// Package: register map, field layout, reset values and enums
package msp_pkg;
  // Register byte addresses (printed offsets are not all multiples of four)
  localparam logic [11:0] MSP_IDX_CONFIG_A   = 12'h046;
  localparam logic [11:0] MSP_IDX_CONFIG_B   = 12'h047;
  localparam logic [11:0] MSP_IDX_FREQ_EST   = 12'h048;
  localparam logic [11:0] MSP_IDX_STATUS     = 12'h049;
  localparam logic [13:0] MSP_ADDR_CONFIG_A  = {MSP_IDX_CONFIG_A, 2'b00};
  localparam logic [13:0] MSP_ADDR_CONFIG_B  = {MSP_IDX_CONFIG_B, 2'b00};
  localparam logic [13:0] MSP_ADDR_FREQ_EST  = {MSP_IDX_FREQ_EST, 2'b00};
  localparam logic [13:0] MSP_ADDR_STATUS    = {MSP_IDX_STATUS, 2'b00};
  // Reset values
  localparam logic [7:0]  MSP_RST_CONFIG_A   = 8'h45;
  localparam logic [7:0]  MSP_RST_CONFIG_B   = 8'h2E;
  // Field positions in modem_config_a
  localparam int          MSP_ZC_HI          = 7;
  localparam int          MSP_ZC_LO          = 6;
  localparam int          MSP_AVG_BIT        = 5;
  localparam int          MSP_PRE_HI         = 4;
  localparam int          MSP_PRE_LO         = 1;
  localparam int          MSP_FILT_BIT       = 0;
  // Field positions in modem_config_b
  localparam int          MSP_THR_HI         = 4;
  localparam int          MSP_THR_LO         = 0;
  localparam logic [7:0]  MSP_CFGB_MASK      = 8'h3F;
  // Preamble: field plus two bytes, two zero symbols per byte
  localparam logic [4:0]  MSP_PRE_BYTE_ADD   = 5'h02;
  localparam logic [5:0]  MSP_SYM_PER_BYTE   = 6'h02;

  typedef enum logic [1:0] {
    MSP_RX_SEARCH,
    MSP_RX_LOCKED
  } msp_rx_e;

  typedef enum logic [1:0] {
    MSP_TX_IDLE,
    MSP_TX_PREAMBLE,
    MSP_TX_DELIM
  } msp_tx_e;
endpackage : msp_pkg

/* File: logic/msp_top.sv */
// Top: APB register file for modem sync and preamble configuration
`timescale 1ns/10ps
module msp_top
  import msp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        demod_en,
  input  wire logic        sym_valid,
  input  wire logic        sym_is_zero,
  input  wire logic [4:0]  sym_corr,
  input  wire logic        sync_word,
  input  wire logic        frame_end,
  input  wire logic [7:0]  offset_sample,
  input  wire logic        tx_start,
  input  wire logic        tx_sym_tick,
  output logic             tx_sym_zero,
  output logic             tx_delim,
  output logic             tx_extra_filter,
  output logic             sync_pulse
);
  typedef struct packed {
    logic [7:0]  cfg_a;
    logic [7:0]  cfg_b;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } msp_regs_s;

  msp_regs_s st_q, st_d;
  msp_cfg_if cfg ();

  // Address decode, shared by read and write paths
  function automatic logic addr_hit(input logic [13:0] a);
    addr_hit = (a == MSP_ADDR_CONFIG_A) || (a == MSP_ADDR_CONFIG_B)
            || (a == MSP_ADDR_FREQ_EST) || (a == MSP_ADDR_STATUS);
  endfunction : addr_hit

  // Field views of the configuration registers
  assign cfg.zero_count = st_q.cfg_a[MSP_ZC_HI:MSP_ZC_LO];
  assign cfg.avg_mode   = st_q.cfg_a[MSP_AVG_BIT];
  assign cfg.pre_len    = st_q.cfg_a[MSP_PRE_HI:MSP_PRE_LO];
  assign cfg.tx_filter  = st_q.cfg_a[MSP_FILT_BIT];
  assign cfg.correlation_threshold   = st_q.cfg_b[MSP_THR_HI:MSP_THR_LO];

  // APB slave: one wait state, answer on the second access cycle
  always_comb begin
    st_d       = st_q;
    st_d.ready = 1'b0;
    st_d.err   = 1'b0;
    if (psel && penable && !st_q.ready) begin
      st_d.ready = 1'b1;
      st_d.err   = !addr_hit(paddr);
      st_d.rdata = 32'h0000_0000;
      if (pwrite && pstrb[0]) begin
        if (paddr == MSP_ADDR_CONFIG_A) st_d.cfg_a = pwdata[7:0];
        if (paddr == MSP_ADDR_CONFIG_B)
          st_d.cfg_b = pwdata[7:0] & MSP_CFGB_MASK;
      end else if (!pwrite) begin
        case (paddr)
          MSP_ADDR_CONFIG_A: st_d.rdata[7:0] = st_q.cfg_a;
          MSP_ADDR_CONFIG_B: st_d.rdata[7:0] = st_q.cfg_b;
          MSP_ADDR_FREQ_EST: st_d.rdata[7:0] = cfg.freq_est;
          MSP_ADDR_STATUS:
            st_d.rdata[1:0] = {cfg.tx_busy, cfg.sync_found};
          default: st_d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // Register state; config resets to documented values
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{cfg_a: MSP_RST_CONFIG_A, cfg_b: MSP_RST_CONFIG_B,
                default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata  = st_q.rdata;
  assign pready  = st_q.ready;
  assign pslverr = st_q.err;

  // Modem control datapath
  msp_modem_ctrl u_ctrl (
    .core_clk        (core_clk),
    .rst_b           (rst_b),
    .cfg             (cfg),
    .demod_en        (demod_en),
    .sym_valid       (sym_valid),
    .sym_is_zero     (sym_is_zero),
    .sym_corr        (sym_corr),
    .sync_word       (sync_word),
    .frame_end       (frame_end),
    .offset_sample   (offset_sample),
    .tx_start        (tx_start),
    .tx_sym_tick     (tx_sym_tick),
    .tx_sym_zero     (tx_sym_zero),
    .tx_delim        (tx_delim),
    .tx_extra_filter (tx_extra_filter),
    .sync_pulse      (sync_pulse)
  );
endmodule : msp_top

/* File: verification/msp_top_asserts.sv */
// Checker: APB timing and modem pulse causes at the msp_top ports
`timescale 1ns/10ps
module msp_top_asserts
  import msp_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sync_word,
  input wire logic        tx_sym_tick,
  input wire logic        tx_sym_zero,
  input wire logic        tx_delim,
  input wire logic        sync_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // One wait state, answer stands one cycle
  chk_apb_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not one cycle after access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  // Error flag follows the address map
  chk_cfg_ok: assert property (
    pready && paddr == MSP_ADDR_CONFIG_A |-> !pslverr)
    else $error("error on config register");
  chk_unmapped_err: assert property (
    pready && paddr < MSP_ADDR_CONFIG_A |-> pslverr)
    else $error("no error on unmapped address");
  chk_rd_upper: assert property (
    pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_cfgb_top: assert property (
    pready && !pwrite && paddr == MSP_ADDR_CONFIG_B |-> prdata[7:6] == 2'b00)
    else $error("reserved config_b bits set");
  // Transmit and sync pulses need a cause
  chk_zero_tick: assert property (tx_sym_zero |-> $past(tx_sym_tick))
    else $error("zero symbol without tick");
  chk_delim_tick: assert property (
    tx_delim |-> $past(tx_sym_tick) && !tx_sym_zero)
    else $error("delimiter without tick");
  chk_sync_word: assert property (
    sync_pulse |-> $past(sync_word) || $past(sync_word, 2))
    else $error("sync without sync word");
endmodule : msp_top_asserts

bind msp_top msp_top_asserts chk_u (.core_clk, .rst_b, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .sync_word, .tx_sym_tick,
  .tx_sym_zero, .tx_delim, .sync_pulse);

/* File: verification/testbench.sv */
// Testbench: register, transmit preamble and sync checks for msp_top
`timescale 1ns/10ps
module testbench;
  import msp_pkg::*;
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [4:0]  sym_corr;
  logic [7:0]  offset_sample;
  logic        demod_en, sym_valid, sym_is_zero, sync_word, frame_end;
  logic        tx_start, tx_sym_tick, tx_sym_zero, tx_delim, tx_extra_filter;
  logic        sync_pulse;
  int          fails = 0, samples_checked = 0, syncs = 0, zeros = 0;
  int          delims = 0, base, dbase;

  msp_top dut_u (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .demod_en, .sym_valid, .sym_is_zero,
    .sym_corr, .sync_word, .frame_end, .offset_sample, .tx_start, .tx_sym_tick,
    .tx_sym_zero, .tx_delim, .tx_extra_filter, .sync_pulse);

  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Count one-cycle output pulses
  always @(posedge core_clk) begin
    syncs <= syncs + int'(sync_pulse === 1'b1);
    zeros <= zeros + int'(tx_sym_zero === 1'b1);
    delims <= delims + int'(tx_delim === 1'b1);
  end

  task results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk) penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      results();
    end
  endtask : apb

  task rdc(input logic [13:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task sym(input logic z, input logic [4:0] c);
    @(posedge core_clk);
    sym_valid <= 1'b1;
    sym_is_zero <= z;
    sym_corr <= c;
    @(posedge core_clk) sym_valid <= 1'b0;
  endtask : sym

  task fend();
    @(posedge core_clk) frame_end <= 1'b1;
    @(posedge core_clk) frame_end <= 1'b0;
  endtask : fend

  // Clear count, send n zeros (first with correlation c), then sync word
  task hunt(input int n, input logic [4:0] c, input int exp);
    base = syncs;
    sym(1'b0, 5'h1F);
    for (int i = 0; i < n; i++) sym(1'b1, i == 0 ? c : 5'h00);
    @(posedge core_clk) sync_word <= 1'b1;
    @(posedge core_clk) sync_word <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(syncs - base, exp);
  endtask : hunt

  // Preamble length p; last extra tick must produce nothing
  task tx(input logic [3:0] p);
    apb(1'b1, MSP_ADDR_CONFIG_A, {24'h0, 3'b100, p, p[0]});
    base = zeros;
    dbase = delims;
    @(posedge core_clk) tx_start <= 1'b1;
    @(posedge core_clk) tx_start <= 1'b0;
    rdc(MSP_ADDR_STATUS, 32'h2);
    repeat (2 * p + 6) begin
      @(posedge core_clk) tx_sym_tick <= 1'b1;
      @(posedge core_clk) tx_sym_tick <= 1'b0;
    end
    repeat (3) @(posedge core_clk);
    chk(zeros - base, 2 * (p + 2));
    chk(delims - dbase, 1);
    chk(tx_extra_filter, p[0]);
  endtask : tx

  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    {sym_valid, sym_is_zero, sym_corr, sync_word, frame_end} = '0;
    {tx_start, tx_sym_tick} = '0;
    demod_en = 1'b1;
    offset_sample = 8'h40;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    rdc(MSP_ADDR_CONFIG_A, 32'h45);
    rdc(MSP_ADDR_CONFIG_B, 32'h2E);
    rdc(14'h004, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, 14'h004, 32'hFF);
    apb(1'b1, MSP_ADDR_CONFIG_B, 32'hFF);
    rdc(MSP_ADDR_CONFIG_B, 32'h3F);
    apb(1'b1, MSP_ADDR_CONFIG_B, 32'h14);
    tx(4'h0);
    tx(4'h2);
    tx(4'hF);
    // Count codes start at 1, the reserved code is never written
    for (int z = 1; z < 4; z++) begin
      apb(1'b1, MSP_ADDR_CONFIG_A, {24'h0, z[1:0], 6'h05});
      hunt(z - 1, 5'h15, 0);
      hunt(z, 5'h14, 0);
      hunt(z, 5'h15, 1);
      rdc(MSP_ADDR_STATUS, 32'h1);
      fend();
      rdc(MSP_ADDR_STATUS, 32'h0);
    end
    // Averaging locked after sync, then restarted
    repeat (30) @(posedge core_clk);
    hunt(3, 5'h15, 1);
    offset_sample <= 8'h00;
    repeat (30) @(posedge core_clk);
    rdc(MSP_ADDR_FREQ_EST, 32'h40);
    fend();
    rdc(MSP_ADDR_FREQ_EST, 32'h0);
    // Continuous averaging keeps tracking after sync
    apb(1'b1, MSP_ADDR_CONFIG_A, 32'hA5);
    offset_sample <= 8'h40;
    repeat (30) @(posedge core_clk);
    hunt(2, 5'h15, 1);
    offset_sample <= 8'h00;
    repeat (40) @(posedge core_clk);
    rdc(MSP_ADDR_FREQ_EST, 32'h3);
    results();
  end
endmodule : testbench
